// File: sticky_irq.sv
/*
 * Sticky interrupt status bits with an enable mask and a write-one-to-clear
 * port, folded into one level interrupt.
 * Assumes set and clear pulses come from logic on the same clock.
 */
`timescale 1ns/1ps

module sticky_irq #(
    parameter int N = 2 // Number of event bits
) (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic [N-1:0] set, // Event pulses, one per bit
    input wire logic [N-1:0] clr, // Clear pulses, one per bit
    input wire logic [N-1:0] en, // Enable mask
    output logic [N-1:0] status, // Sticky status bits
    output logic irq // High while an enabled bit is set
);
    // Status state and its next value
    logic [N-1:0] status_q;
    logic [N-1:0] status_d;

    // A set arriving with its clear wins, so no event is lost
    always_comb begin
        status_d = (status_q & ~clr) | set;
    end

    // Status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    assign status = status_q;
    assign irq = |(status_q & en);

    // Set must win over a simultaneous clear
    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (set[0] && clr[0]) |=> status_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost against clear");
endmodule : sticky_irq

// File: cycle_counter.sv
/*
 * Constants package and the event monitor cycle counter: one shared down
 * counter, four per-group limit registers, reload, toggle and pass-through of
 * the count across group switches; limits and mode set over APB, count not readable.
 * Assumes the comparators and the group sequencer run on pclk and give
 * one-cycle request pulses in the seq_req_t bundle.
 */
package cycle_counter_pkg;
    // Register byte offsets
    localparam logic [7:0] LIMIT0_OFF = 8'h00;
    localparam logic [7:0] LIMIT1_OFF = 8'h04;
    localparam logic [7:0] LIMIT2_OFF = 8'h08;
    localparam logic [7:0] LIMIT3_OFF = 8'h0C;
    localparam logic [7:0] MODE_OFF = 8'h10;
    localparam logic [7:0] STATUS_OFF = 8'h14;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h18;
    localparam logic [7:0] IRQ_EN_OFF = 8'h1C;
    localparam logic [7:0] IRQ_CLR_OFF = 8'h20;
    // Widths and counts
    localparam int COUNT_W = 16;
    localparam int NUM_GROUPS = 4;
    localparam int NUM_EVENTS = 2;
    // Reset values
    localparam logic [15:0] LIMIT_RST = 16'h0000;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [1:0] IRQ_EN_RST = 2'h0;
    // Field positions
    localparam int EV_LIMIT_BIT = 0;
    localparam int EV_TOGGLE_BIT = 1;
    localparam int ST_RUN_BIT = 0;
    localparam int ST_LIMIT_BIT = 1;
    localparam int ST_TOGGLE_BIT = 2;
    localparam int ST_GROUP_LSB = 3;
    // Per-group count action
    typedef enum logic [1:0] {
        COUNT_NONE,
        COUNT_DECREMENT,
        COUNT_TOGGLE
    } count_mode_t;
    // Request bundle from comparators and sequencer
    typedef struct packed {
        logic bus_cycle; // One target bus cycle completed
        logic qualified; // Decrement clause satisfied this cycle
        logic toggle_event; // Toggle-count action fired
        logic group_switch; // Group-switch action fired
        logic [1:0] new_group; // Destination group, 0 is group 1
        logic reload; // Reload-count action fired
        logic [1:0] reload_group; // Group whose limit is loaded
    } seq_req_t;
endpackage : cycle_counter_pkg

`timescale 1ns/1ps

module cycle_counter #(
    parameter int CW = cycle_counter_pkg::COUNT_W // Counter width
) (
    input wire logic pclk, // Bus clock, 40 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic run_mode, // Emulation running
    input wire cycle_counter_pkg::seq_req_t seq_req, // Sequencer requests
    output logic count_limit_event, // Count reached zero in run mode
    output logic toggle_state_counting, // Toggle state is counting
    output logic [1:0] current_group, // Active trigger group
    output logic irq // Interrupt, level
);
    import cycle_counter_pkg::*;

    // All block state but the interrupt status bits in one record
    typedef struct packed {
        logic [NUM_GROUPS-1:0][CW-1:0] limit; // Per-group count limits
        logic [7:0] mode; // Two mode bits per group
        logic [CW-1:0] count; // Shared down counter
        logic [1:0] group; // Current group
        logic toggle_on; // Toggle counting state
        logic run_prev; // Run mode one cycle ago
        logic limit_prev; // Limit event one cycle ago
        logic [NUM_EVENTS-1:0] irq_en; // Interrupt enables
        logic [31:0] prdata; // Read data register
    } state_t;

    state_t q; // Registered state
    state_t d; // Next state

    logic run_entry; // First cycle of run mode
    logic count_en; // Counting allowed in this group
    logic count_now; // Decrement this cycle
    logic apb_wr; // APB write access phase
    logic apb_setup; // APB setup phase
    logic addr_ok; // Address is mapped
    logic [NUM_EVENTS-1:0] ev_set; // Event pulses
    logic [NUM_EVENTS-1:0] ev_clr; // Clear pulses
    logic [NUM_EVENTS-1:0] ev_status; // Sticky status
    count_mode_t gmode; // Mode of current group

    assign run_entry = run_mode && !q.run_prev;
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;

    // Address decode
    always_comb begin
        if (paddr == LIMIT0_OFF || paddr == LIMIT1_OFF || paddr == LIMIT2_OFF || paddr == LIMIT3_OFF) begin
            addr_ok = 1'b1;
        end else if (paddr == MODE_OFF || paddr == STATUS_OFF || paddr == IRQ_STAT_OFF) begin
            addr_ok = 1'b1;
        end else if (paddr == IRQ_EN_OFF || paddr == IRQ_CLR_OFF) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // Counting enable from the current group's action
    always_comb begin
        gmode = count_mode_t'(q.mode[2*q.group +: 2]);
        case (gmode)
            COUNT_DECREMENT: count_en = 1'b1;
            COUNT_TOGGLE: count_en = q.toggle_on;
            default: count_en = 1'b0;
        endcase
    end

    // Decrement only on a qualified bus cycle, never below zero
    assign count_now = seq_req.bus_cycle && seq_req.qualified && count_en && (q.count != '0);

    // Next-state logic
    always_comb begin
        d = q;
        d.run_prev = run_mode;
        d.limit_prev = count_limit_event;
        if (run_entry) begin
            // Load group 1 limit, start in group 1, toggle idle
            d.count = q.limit[0];
            d.group = 2'h0;
            d.toggle_on = 1'b0;
        end else if (run_mode) begin
            if (seq_req.toggle_event) begin
                d.toggle_on = !q.toggle_on;
            end
            if (seq_req.group_switch) begin
                d.group = seq_req.new_group;
            end
            if (seq_req.reload) begin
                d.count = q.limit[seq_req.reload_group];
            end else if (count_now) begin
                d.count = q.count - CW'(1);
            end
        end
        // Register writes
        if (apb_wr) begin
            if (paddr == LIMIT0_OFF) begin
                d.limit[0] = pwdata[CW-1:0];
            end else if (paddr == LIMIT1_OFF) begin
                d.limit[1] = pwdata[CW-1:0];
            end else if (paddr == LIMIT2_OFF) begin
                d.limit[2] = pwdata[CW-1:0];
            end else if (paddr == LIMIT3_OFF) begin
                d.limit[3] = pwdata[CW-1:0];
            end else if (paddr == MODE_OFF) begin
                d.mode = pwdata[7:0];
            end else if (paddr == IRQ_EN_OFF) begin
                d.irq_en = pwdata[NUM_EVENTS-1:0];
            end
        end
        // Read data captured in setup; count itself is never mapped
        if (apb_setup) begin
            d.prdata = 32'h0000_0000;
            if (paddr == LIMIT0_OFF) begin
                d.prdata[CW-1:0] = q.limit[0];
            end else if (paddr == LIMIT1_OFF) begin
                d.prdata[CW-1:0] = q.limit[1];
            end else if (paddr == LIMIT2_OFF) begin
                d.prdata[CW-1:0] = q.limit[2];
            end else if (paddr == LIMIT3_OFF) begin
                d.prdata[CW-1:0] = q.limit[3];
            end else if (paddr == MODE_OFF) begin
                d.prdata[7:0] = q.mode;
            end else if (paddr == STATUS_OFF) begin
                d.prdata[ST_RUN_BIT] = run_mode;
                d.prdata[ST_LIMIT_BIT] = count_limit_event;
                d.prdata[ST_TOGGLE_BIT] = q.toggle_on;
                d.prdata[ST_GROUP_LSB +: 2] = q.group;
            end else if (paddr == IRQ_STAT_OFF) begin
                d.prdata[NUM_EVENTS-1:0] = ev_status;
            end else if (paddr == IRQ_EN_OFF) begin
                d.prdata[NUM_EVENTS-1:0] = q.irq_en;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.limit <= {NUM_GROUPS{LIMIT_RST[CW-1:0]}};
            q.mode <= MODE_RST;
            q.count <= '0;
            q.group <= 2'h0;
            q.toggle_on <= 1'b0;
            q.run_prev <= 1'b0;
            q.limit_prev <= 1'b0;
            q.irq_en <= IRQ_EN_RST;
            q.prdata <= 32'h0000_0000;
        end else begin
            q <= d;
        end
    end

    // Limit event holds while the count sits at zero in run mode
    assign count_limit_event = q.run_prev && (q.count == '0);
    assign toggle_state_counting = q.toggle_on;
    assign current_group = q.group;

    // APB answers in the first access cycle
    assign prdata = q.prdata;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !addr_ok;

    // Interrupt events: limit reached, toggle applied
    always_comb begin
        ev_set = '0;
        ev_set[EV_LIMIT_BIT] = count_limit_event && !q.limit_prev;
        ev_set[EV_TOGGLE_BIT] = run_mode && !run_entry && seq_req.toggle_event;
        ev_clr = (apb_wr && paddr == IRQ_CLR_OFF) ? pwdata[NUM_EVENTS-1:0] : '0;
    end

    sticky_irq #(.N(NUM_EVENTS)) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .set(ev_set),
        .clr(ev_clr),
        .en(q.irq_en),
        .status(ev_status),
        .irq(irq)
    );

    // Assertions
    property p_run_load;
        @(posedge pclk) disable iff (!presetn)
        run_entry |=> (q.count == $past(q.limit[0])) && (q.group == 2'h0);
    endproperty
    a_run_load: assert property (p_run_load) else $error("run entry did not load group 1 limit");

    property p_decrement;
        @(posedge pclk) disable iff (!presetn)
        (run_mode && !run_entry && !seq_req.reload && count_now) |=> (q.count == $past(q.count) - CW'(1));
    endproperty
    a_decrement: assert property (p_decrement) else $error("qualified cycle did not decrement");

    property p_unqualified;
        @(posedge pclk) disable iff (!presetn)
        (run_mode && !run_entry && !seq_req.reload && !(seq_req.bus_cycle && seq_req.qualified)) |=> $stable(q.count);
    endproperty
    a_unqualified: assert property (p_unqualified) else $error("count moved without qualified cycle");

    property p_limit;
        @(posedge pclk) disable iff (!presetn)
        (run_mode && !run_entry && !seq_req.reload && count_now && q.count == CW'(1)) |=> count_limit_event;
    endproperty
    a_limit: assert property (p_limit) else $error("zero count without limit event");

    property p_reload;
        @(posedge pclk) disable iff (!presetn)
        (run_mode && !run_entry && seq_req.reload) |=> (q.count == $past(q.limit[seq_req.reload_group]));
    endproperty
    a_reload: assert property (p_reload) else $error("reload did not copy limit");

    property p_pass_through;
        @(posedge pclk) disable iff (!presetn)
        (run_mode && !run_entry && seq_req.group_switch && !seq_req.reload && !count_now) |=> $stable(q.count);
    endproperty
    a_pass_through: assert property (p_pass_through) else $error("group switch lost the count");

    property p_toggle;
        @(posedge pclk) disable iff (!presetn)
        (run_mode && !run_entry && seq_req.toggle_event) |=> (q.toggle_on != $past(q.toggle_on));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle event did not invert state");

    property p_hold_zero;
        @(posedge pclk) disable iff (!presetn)
        (q.run_prev && q.count == '0 && run_mode && !seq_req.reload) |=> (q.count == '0);
    endproperty
    a_hold_zero: assert property (p_hold_zero) else $error("counter left zero without reload");

    property p_frozen;
        @(posedge pclk) disable iff (!presetn)
        !run_mode |=> $stable(q.count) && $stable(q.toggle_on);
    endproperty
    a_frozen: assert property (p_frozen) else $error("counter changed while paused");

    property p_no_action;
        @(posedge pclk) disable iff (!presetn)
        (run_mode && !run_entry && gmode == COUNT_NONE && !seq_req.reload) |=> $stable(q.count);
    endproperty
    a_no_action: assert property (p_no_action) else $error("counted with no count action");

    property p_no_count_read;
        @(posedge pclk) disable iff (!presetn)
        (apb_setup && !pwrite && !addr_ok) |=> (prdata == 32'h0000_0000);
    endproperty
    a_no_count_read: assert property (p_no_count_read) else $error("unmapped read returned data");

    // Covers
    c_limit_hit: cover property (@(posedge pclk) disable iff (!presetn) $rose(count_limit_event));
    c_switch_reload: cover property (@(posedge pclk) disable iff (!presetn) run_mode && seq_req.group_switch && seq_req.reload);
    c_toggle_count: cover property (@(posedge pclk) disable iff (!presetn) count_now && gmode == COUNT_TOGGLE);
endmodule : cycle_counter

// File: seq_model.sv
/*
 * Stand-in for the comparators and the trigger group sequencer: turns a
 * scenario's request into a one-cycle seq_req pulse.
 * Assumes it shares pclk with the counter.
 */
`timescale 1ns/1ps

module seq_model
    import cycle_counter_pkg::*;
(
    input wire logic pclk, // Bus clock
    output cycle_counter_pkg::seq_req_t seq_req // Request pulses to the counter
);
    // Idle until a scenario asks for a pulse
    initial seq_req = '0;

    // Raise the request after one edge, drop it after the next, let it settle
    task send(input seq_req_t r);
        @(posedge pclk);
        seq_req <= r;
        @(posedge pclk);
        seq_req <= '0;
        #1;
    endtask : send
endmodule : seq_model

// File: tb.sv
/*
 * Self-checking bench for the cycle counter: APB master tasks and one task per
 * scenario.
 * Assumes cycle_counter_pkg and the seq_model stand-in are compiled first.
 */
`timescale 1ns/1ps

module tb;
    import cycle_counter_pkg::*;
    logic pclk = 1'b0; // Bus clock
    logic presetn = 1'b0; // Reset, active low
    logic psel = 1'b0; // APB select
    logic penable = 1'b0; // APB enable
    logic pwrite = 1'b0; // APB direction
    logic [7:0] paddr = 8'h00; // APB address
    logic [31:0] pwdata = 32'h0; // APB write data
    logic [31:0] prdata; // APB read data
    logic pready; // APB ready
    logic pslverr; // APB error
    logic run_mode = 1'b0; // Emulation running
    seq_req_t seq_req; // Sequencer pulses
    logic cle; // Limit event
    logic tsc; // Toggle state
    logic [1:0] grp; // Active group
    logic irq; // Interrupt
    logic [31:0] rv; // Last read data
    logic re; // Last read error
    int n_errors = 0;
    int check_count = 0;

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    cycle_counter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .run_mode(run_mode), .seq_req(seq_req), .count_limit_event(cle), .toggle_state_counting(tsc),
        .current_group(grp), .irq(irq));
    seq_model partner (.pclk(pclk), .seq_req(seq_req));

    // Compare and count
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk

    // One APB transfer, held until pready is seen at a rising edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rv);
    endtask : rchk

    // Change run mode; entry load lands on the next edge
    task go(input logic v);
        @(posedge pclk);
        run_mode <= v;
        repeat (2) @(posedge pclk);
        #1;
    endtask : go

    // One sequencer pulse, built field by field
    task pulse(input logic cyc, input logic qual, input logic tgl, input logic sw, input logic [1:0] ng,
        input logic rl, input logic [1:0] rg);
        seq_req_t r;
        r.bus_cycle = cyc;
        r.qualified = qual;
        r.toggle_event = tgl;
        r.group_switch = sw;
        r.new_group = ng;
        r.reload = rl;
        r.reload_group = rg;
        partner.send(r);
    endtask : pulse

    // A qualified target bus cycle
    task qcyc;
        pulse(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0);
    endtask : qcyc

    // A toggle-count event
    task tog;
        pulse(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 2'h0);
    endtask : tog

    // A group switch, with or without a reload riding along
    task hop(input logic [1:0] g, input logic rl, input logic [1:0] rg);
        pulse(1'b0, 1'b0, 1'b0, 1'b1, g, rl, rg);
    endtask : hop

    // Reset values, read-back, unmapped place
    task t_regs;
        for (int k = 0; k < NUM_GROUPS; k++) begin
            rchk(LIMIT0_OFF + 8'(4 * k), 32'h0, "limit reset");
            wr(LIMIT0_OFF + 8'(4 * k), 32'hFFFF0000 | 32'(k + 1));
            rchk(LIMIT0_OFF + 8'(4 * k), 32'(k + 1), "limit rw");
        end
        rchk(MODE_OFF, 32'(MODE_RST), "mode reset");
        rchk(IRQ_EN_OFF, 32'(IRQ_EN_RST), "irq en reset");
        rchk(IRQ_CLR_OFF, 32'h0, "irq clr read");
        rchk(8'h24, 32'h0, "unmapped data");
        chk("unmapped err", 32'h1, 32'(re));
    endtask : t_regs

    // Decrement mode, hold at zero, interrupt, pause
    task t_dec;
        wr(LIMIT0_OFF, 32'h2);
        wr(MODE_OFF, 32'h1);
        wr(IRQ_EN_OFF, 32'h1);
        go(1'b1);
        pulse(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0);
        pulse(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0);
        qcyc();
        chk("limit early", 32'h0, 32'(cle));
        qcyc();
        chk("limit at zero", 32'h1, 32'(cle));
        qcyc();
        chk("limit held", 32'h1, 32'(cle));
        chk("irq raised", 32'h1, 32'(irq));
        rchk(IRQ_STAT_OFF, 32'h1, "irq stat");
        wr(IRQ_EN_OFF, 32'h0);
        chk("irq masked", 32'h0, 32'(irq));
        wr(IRQ_CLR_OFF, 32'h3);
        rchk(IRQ_STAT_OFF, 32'h0, "irq cleared");
        go(1'b0);
        chk("limit paused", 32'h0, 32'(cle));
    endtask : t_dec

    // Toggle mode: idle until first toggle, each toggle inverts
    task t_tog;
        wr(LIMIT0_OFF, 32'h1);
        wr(MODE_OFF, 32'h2);
        go(1'b1);
        chk("toggle start", 32'h0, 32'(tsc));
        qcyc();
        chk("idle no count", 32'h0, 32'(cle));
        tog();
        chk("toggle on", 32'h1, 32'(tsc));
        tog();
        chk("toggle off", 32'h0, 32'(tsc));
        qcyc();
        chk("off no count", 32'h0, 32'(cle));
        tog();
        qcyc();
        chk("on counts", 32'h1, 32'(cle));
        rchk(IRQ_STAT_OFF, 32'h3, "irq stat both");
        wr(IRQ_CLR_OFF, 32'h3);
        go(1'b0);
        tog();
        chk("toggle frozen", 32'h1, 32'(tsc));
        rchk(STATUS_OFF, 32'h4, "status paused");
    endtask : t_tog

    // Group switch keeps the count unless a reload rides along
    task t_grp;
        wr(LIMIT0_OFF, 32'h3);
        wr(LIMIT1_OFF, 32'h5);
        wr(LIMIT2_OFF, 32'h1);
        wr(MODE_OFF, 32'h15);
        go(1'b1);
        qcyc();
        hop(2'h1, 1'b0, 2'h0);
        chk("group switched", 32'h1, 32'(grp));
        qcyc();
        chk("kept count", 32'h0, 32'(cle));
        qcyc();
        chk("kept count zero", 32'h1, 32'(cle));
        hop(2'h2, 1'b1, 2'h2);
        chk("switch reload", 32'h0, 32'(cle));
        qcyc();
        chk("reloaded limit", 32'h1, 32'(cle));
        hop(2'h3, 1'b1, 2'h2);
        qcyc();
        chk("mode none", 32'h0, 32'(cle));
        chk("last group", 32'h3, 32'(grp));
        rchk(STATUS_OFF, 32'h19, "status running");
        wr(MODE_OFF, 32'hD5);
        rchk(MODE_OFF, 32'hD5, "mode rw");
        qcyc();
        chk("mode three", 32'h0, 32'(cle));
        go(1'b0);
    endtask : t_grp

    // Verdict and end of run
    task summarize;
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    // Reset for three cycles, then the scenarios
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_dec();
        t_tog();
        t_grp();
        summarize();
    end

    // Watchdog, far beyond the roughly 170 cycles the scenarios need
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
endmodule : tb
